// ==== inc/fbioc_map.svh ====
`ifndef FBIOC_MAP_SVH
`define FBIOC_MAP_SVH
// Configuration codes
`define FBIOC_CFG_NONE      8'h00
`define FBIOC_CFG_W1        8'h50
`define FBIOC_CFG_W2        8'h51
`define FBIOC_CFG_W3        8'h52
`define FBIOC_CFG_W4        8'h53
`define FBIOC_CFG_W5        8'h54
`define FBIOC_CFG_W7        8'h56
`define FBIOC_CFG_W9        8'h58
`define FBIOC_CFG_CU_CMD    8'h31
`define FBIOC_CFG_CU_MOD    8'h15
`define FBIOC_CFG_CU_BOTH0  8'hC0
`define FBIOC_CFG_CU_BOTH1  8'h01
`define FBIOC_CFG_CU_BOTH2  8'h07
// Command codes
`define FBIOC_CMD_CLR_CNT   8'h08
`define FBIOC_CMD_COLD      8'hF8
`define FBIOC_CMD_WARM      8'hF9
`define FBIOC_CMD_PASSIVE   8'hF5
`define FBIOC_CMD_ACTIVE    8'hF6
`define FBIOC_CMD_SWAP      8'hF7
`define FBIOC_PARAM_ALL     8'h00
// Lengths in bytes, then command word reset value
`define FBIOC_GSTAT_BYTES   3'h2
`define FBIOC_MSTAT_BYTES   4'h6
`define FBIOC_CMD_RESET     16'h0000
`endif

// ==== inc/fbioc_pkg.sv ====
package fbioc_pkg;
	typedef enum logic [1:0] {
		FBIOC_CU_NONE = 2'h0,
		FBIOC_CU_CMD  = 2'h1,
		FBIOC_CU_MOD  = 2'h2,
		FBIOC_CU_BOTH = 2'h3
	} fbioc_cu_mode_t;
	typedef enum logic [1:0] {
		FBIOC_ST_IDLE = 2'h0,
		FBIOC_ST_CU   = 2'h1,
		FBIOC_ST_SLOT = 2'h3,
		FBIOC_ST_DONE = 2'h2
	} fbioc_cfg_state_t;
endpackage : fbioc_pkg

// ==== core/fbioc_skid.sv ====
`timescale 1ns/1ps
module fbioc_skid #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	// Two entries so a stalled receiver never drops a byte; outputs are flops
	logic [WIDTH-1:0] main_r;
	logic [WIDTH-1:0] side_r;
	logic             main_vld_r;
	logic             side_vld_r;
	logic             main_free;
	logic             push;

	initial begin
		if (WIDTH < 1) $error("fbioc_skid: WIDTH must be positive");
	end

	assign main_free = !main_vld_r || out_ready;
	assign push      = in_valid && in_ready;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			main_vld_r <= 1'b0;
			side_vld_r <= 1'b0;
		end else if (main_free) begin
			main_vld_r <= side_vld_r || push;
			side_vld_r <= 1'b0;
		end else if (push) begin
			side_vld_r <= 1'b1;
		end
	end

	// Side entry only fills while the receiver stalls a held word
	always_ff @(posedge sys_clk) begin
		if (main_free) main_r <= side_vld_r ? side_r : in_data;
		if (push && !main_free) side_r <= in_data;
	end

	assign in_ready  = !side_vld_r;
	assign out_valid = main_vld_r;
	assign out_data  = main_r;
endmodule : fbioc_skid

// ==== core/fbioc_core.sv ====
`timescale 1ns/1ps
`include "fbioc_map.svh"
// How it works
// - Code 50 means one input word
// - Code 51 means two input words
// - Code 52 means three input words
// - Code 54 means five input words
// - Code 56 means seven input words
// - Code 58 means nine input words
// - Com unit entry always leads string
// - Redundant partner gets no separate entry
// - Com unit code 00, 31, 15, C0 01 07
// - Module codes follow in ascending slot order
// - Global status is two leading input bytes
// - Six module status bytes follow global status
// - Status bit set when active and fault-free
// - Command word: parameter byte, then command byte
// - Execute only when command word changes
// - Response starts with global status bytes when the com unit has a command register; module-only starts with module status
// - 08 with zero parameter clears all counters
// - 08 with parameter clears that slot's counter
// - F8 cold start, F9 warm restart
// - F5 makes active unit passive when partner present
// - F6 makes passive unit active when partner present
// - F7 swaps redundancy roles when partner present
module fbioc_core #(
	parameter int NSLOT = 48
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// Com unit layout and slot layout
	input  wire logic [1:0]           cu_mode,
	input  wire logic [NSLOT*3-1:0]   slot_words,
	input  wire logic [NSLOT-1:0]     slot_present,
	// Configuration string read-out
	input  wire logic                 cfg_start,
	output logic                      cfg_valid,
	input  wire logic                 cfg_ready,
	output logic      [7:0]           cfg_byte,
	output logic                      cfg_last,
	// Cyclic request bytes from the link, in order
	input  wire logic                 req_valid,
	input  wire logic [7:0]           req_byte,
	input  wire logic                 req_first,
	// Cyclic response bytes
	input  wire logic                 rsp_start,
	output logic                      rsp_valid,
	input  wire logic                 rsp_ready,
	output logic      [7:0]           rsp_byte,
	// Station state
	input  wire logic [15:0]          global_status,
	input  wire logic [NSLOT-1:0]     mod_active,
	input  wire logic [NSLOT-1:0]     mod_fault,
	input  wire logic                 partner_present,
	// Command effects
	output logic                      clr_all_cnt,
	output logic                      clr_slot_cnt,
	output logic      [7:0]           clr_slot_num,
	output logic                      cold_start,
	output logic                      warm_restart,
	output logic                      unit_active,
	output logic                      partner_take,
	output logic      [15:0]          last_cmd_word
);
	initial begin
		if (NSLOT < 1 || NSLOT > 48) $error("fbioc_core: NSLOT must be 1..48");
	end

	// Slot size index (1..6 for 1,2,3,5,7,9 words; 0 or 7 for none) to its configuration code
	function automatic logic [7:0] fbioc_code(input logic [2:0] w);
		case (w)
			3'h1:    fbioc_code = `FBIOC_CFG_W1;
			3'h2:    fbioc_code = `FBIOC_CFG_W2;
			3'h3:    fbioc_code = `FBIOC_CFG_W3;
			3'h4:    fbioc_code = `FBIOC_CFG_W5;
			3'h5:    fbioc_code = `FBIOC_CFG_W7;
			3'h6:    fbioc_code = `FBIOC_CFG_W9;
			default: fbioc_code = `FBIOC_CFG_NONE;
		endcase
	endfunction : fbioc_code

	// Configuration string
	fbioc_pkg::fbioc_cfg_state_t st_r;
	fbioc_pkg::fbioc_cfg_state_t st_nxt;
	logic [1:0]  cu_idx_r;
	logic [5:0]  slot_r;
	logic [5:0]  last_slot;
	logic        buf_in_ready;
	logic        cfg_push;
	logic [8:0]  cfg_in;
	logic [8:0]  cfg_out;
	logic [1:0]  cu_len;
	logic [7:0]  cu_code;
	logic [2:0]  cur_words;

	// Last populated slot ends the string; trailing empty slots are dropped
	always_comb begin
		last_slot = 6'h0;
		for (int i = 0; i < NSLOT; i++) begin
			if (slot_present[i]) last_slot = 6'(i + 1);
		end
	end

	assign cu_len  = (cu_mode == fbioc_pkg::FBIOC_CU_BOTH) ? 2'h2 : 2'h0;
	assign cu_code = (cu_mode == fbioc_pkg::FBIOC_CU_CMD)  ? `FBIOC_CFG_CU_CMD :
	                 (cu_mode == fbioc_pkg::FBIOC_CU_MOD)  ? `FBIOC_CFG_CU_MOD :
	                 (cu_mode == fbioc_pkg::FBIOC_CU_NONE) ? `FBIOC_CFG_NONE :
	                 (cu_idx_r == 2'h0) ? `FBIOC_CFG_CU_BOTH0 :
	                 (cu_idx_r == 2'h1) ? `FBIOC_CFG_CU_BOTH1 : `FBIOC_CFG_CU_BOTH2;
	assign cur_words = (slot_r != 6'h0) ? slot_words[(slot_r-6'h1)*3 +: 3] : 3'h0;
	assign cfg_push  = buf_in_ready && (st_r == fbioc_pkg::FBIOC_ST_CU ||
	                                    st_r == fbioc_pkg::FBIOC_ST_SLOT);

	// Partner unit shares the single com unit entry: no slot of its own
	always_comb begin
		cfg_in = 9'h0;
		if (st_r == fbioc_pkg::FBIOC_ST_CU) begin
			cfg_in[7:0] = cu_code;
			cfg_in[8]   = (cu_idx_r == cu_len) && (last_slot == 6'h0);
		end else begin
			cfg_in[7:0] = slot_present[slot_r-6'h1] ? fbioc_code(cur_words)
			                                        : `FBIOC_CFG_NONE;
			cfg_in[8]   = (slot_r == last_slot);
		end
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			fbioc_pkg::FBIOC_ST_IDLE: if (cfg_start) st_nxt = fbioc_pkg::FBIOC_ST_CU;
			fbioc_pkg::FBIOC_ST_CU: begin
				if (cfg_push && cu_idx_r == cu_len)
					st_nxt = (last_slot == 6'h0) ? fbioc_pkg::FBIOC_ST_DONE
					                             : fbioc_pkg::FBIOC_ST_SLOT;
			end
			fbioc_pkg::FBIOC_ST_SLOT: begin
				if (cfg_push && slot_r == last_slot) st_nxt = fbioc_pkg::FBIOC_ST_DONE;
			end
			fbioc_pkg::FBIOC_ST_DONE: st_nxt = fbioc_pkg::FBIOC_ST_IDLE;
			default: st_nxt = fbioc_pkg::FBIOC_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r     <= fbioc_pkg::FBIOC_ST_IDLE;
			cu_idx_r <= 2'h0;
			slot_r   <= 6'h0;
		end else begin
			st_r <= st_nxt;
			if (st_r == fbioc_pkg::FBIOC_ST_IDLE) begin
				cu_idx_r <= 2'h0;
				slot_r   <= 6'h1;
			end else if (cfg_push && st_r == fbioc_pkg::FBIOC_ST_CU) begin
				cu_idx_r <= cu_idx_r + 2'h1;
			end else if (cfg_push) begin
				slot_r <= slot_r + 6'h1;
			end
		end
	end

	fbioc_skid #(
		.WIDTH(9)
	) u_cfg_buf (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (cfg_push),
		.in_ready  (buf_in_ready),
		.in_data   (cfg_in),
		.out_valid (cfg_valid),
		.out_ready (cfg_ready),
		.out_data  (cfg_out)
	);
	assign cfg_byte = cfg_out[7:0];
	assign cfg_last = cfg_out[8];

	// Cyclic response
	logic [3:0]  rsp_idx_r;
	logic [3:0]  rsp_idx_nxt;
	logic [3:0]  rsp_len;
	logic [47:0] health_r;
	logic [47:0] health_nxt;
	logic [47:0] health_use;
	logic [63:0] rsp_frame;
	logic [7:0]  rsp_byte_r;
	logic        rsp_run_r;
	logic        rsp_go;
	logic        rsp_step;

	// Byte idx of a frame, most significant first; past the end reads zero
	function automatic logic [7:0] rsp_pick(input logic [63:0] f, input logic [3:0] idx);
		rsp_pick = idx[3] ? 8'h00 : f[63 - 8 * int'(idx[2:0]) -: 8];
	endfunction : rsp_pick

	always_comb begin
		health_nxt = 48'h0;
		health_nxt[NSLOT-1:0] = mod_active & ~mod_fault;
	end
	assign rsp_len = (cu_mode == fbioc_pkg::FBIOC_CU_BOTH) ?
	                 4'(`FBIOC_GSTAT_BYTES) + `FBIOC_MSTAT_BYTES :
	                 (cu_mode == fbioc_pkg::FBIOC_CU_MOD) ? `FBIOC_MSTAT_BYTES :
	                 (cu_mode == fbioc_pkg::FBIOC_CU_CMD) ? 4'(`FBIOC_GSTAT_BYTES) : 4'h0;
	assign rsp_go      = rsp_start && rsp_len != 4'h0;
	assign rsp_step    = rsp_run_r && rsp_ready;
	assign rsp_idx_nxt = rsp_go ? 4'h0 : rsp_idx_r + {3'h0, rsp_step};
	// A fresh snapshot feeds the first byte in the very cycle it is taken
	assign health_use  = rsp_go ? health_nxt : health_r;
	// Global status, then health with slot 1 in bit 0; status-only frames sit left
	assign rsp_frame = (cu_mode == fbioc_pkg::FBIOC_CU_MOD) ? {health_use, 16'h0000}
	                 : {global_status, health_use};
	assign rsp_valid = rsp_run_r;
	assign rsp_byte  = rsp_byte_r;

	// Byte register moves only on a start or a taken byte, so it stands through stalls
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rsp_idx_r  <= 4'h0;
			rsp_run_r  <= 1'b0;
			health_r   <= 48'h0;
			rsp_byte_r <= 8'h00;
		end else begin
			if (rsp_go) health_r <= health_nxt;
			if (rsp_go) begin
				rsp_run_r <= 1'b1;
			end else if (rsp_step && rsp_idx_r == rsp_len - 4'h1) begin
				rsp_run_r <= 1'b0;
			end
			if (rsp_go || rsp_step) begin
				rsp_idx_r  <= rsp_idx_nxt;
				rsp_byte_r <= rsp_pick(rsp_frame, rsp_idx_nxt);
			end
		end
	end

	sequence s_rsp_last;
		rsp_step && rsp_idx_r == rsp_len - 4'h1 && !rsp_start;
	endsequence
	a_status_lead: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rsp_go && cu_mode[0] |=> rsp_valid && rsp_byte == $past(global_status[15:8]))
		else $error("response did not open with global status");
	a_rsp_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_rsp_last |=> !rsp_valid)
		else $error("response ran past its length");

	// Command word
	logic        rx_pos_r;
	logic [7:0]  param_r;
	logic [15:0] cmd_r;
	logic        cmd_new_r;
	logic        has_cmd;
	logic [7:0]  cparam;
	logic [7:0]  ccode;
	logic        zero_p;

	assign has_cmd = cu_mode == fbioc_pkg::FBIOC_CU_CMD || cu_mode == fbioc_pkg::FBIOC_CU_BOTH;

	// First request byte is the parameter, second the command
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rx_pos_r  <= 1'b0;
			param_r   <= 8'h00;
			cmd_r     <= `FBIOC_CMD_RESET;
			cmd_new_r <= 1'b0;
		end else begin
			cmd_new_r <= 1'b0;
			if (req_valid && has_cmd) begin
				if (req_first) begin
					param_r  <= req_byte;
					rx_pos_r <= 1'b1;
				end else if (rx_pos_r) begin
					rx_pos_r <= 1'b0;
					if ({param_r, req_byte} != cmd_r) begin
						cmd_r     <= {param_r, req_byte};
						cmd_new_r <= 1'b1;
					end
				end
			end
		end
	end

	assign cparam = cmd_r[15:8];
	assign ccode  = cmd_r[7:0];
	assign zero_p = cparam == `FBIOC_PARAM_ALL;

	// Pulses one cycle after the changed word is latched
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clr_all_cnt   <= 1'b0;
			clr_slot_cnt  <= 1'b0;
			clr_slot_num  <= 8'h00;
			cold_start    <= 1'b0;
			warm_restart  <= 1'b0;
			unit_active   <= 1'b1;
			partner_take  <= 1'b0;
			last_cmd_word <= 16'h0000;
		end else begin
			last_cmd_word <= cmd_r;
			clr_all_cnt   <= cmd_new_r && ccode == `FBIOC_CMD_CLR_CNT && zero_p;
			clr_slot_cnt  <= cmd_new_r && ccode == `FBIOC_CMD_CLR_CNT && !zero_p;
			clr_slot_num  <= cparam;
			cold_start    <= cmd_new_r && ccode == `FBIOC_CMD_COLD && zero_p;
			warm_restart  <= cmd_new_r && ccode == `FBIOC_CMD_WARM && zero_p;
			partner_take  <= 1'b0;
			if (cmd_new_r && zero_p && partner_present) begin
				if (ccode == `FBIOC_CMD_PASSIVE && unit_active) begin
					unit_active  <= 1'b0;
					partner_take <= 1'b1;
				end else if (ccode == `FBIOC_CMD_ACTIVE && !unit_active) begin
					unit_active  <= 1'b1;
					partner_take <= 1'b1;
				end else if (ccode == `FBIOC_CMD_SWAP) begin
					unit_active  <= !unit_active;
					partner_take <= 1'b1;
				end
			end
		end
	end

	a_repeat_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		req_valid && !req_first && rx_pos_r && {param_r, req_byte} == cmd_r |=> !cmd_new_r)
		else $error("unchanged command word executed");
	a_change_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_new_r |-> cmd_r != $past(cmd_r))
		else $error("command fired without change");
	a_clear_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_new_r && ccode == 8'h08 && cparam == 8'h00 |=> clr_all_cnt && !clr_slot_cnt)
		else $error("clear-all not issued");
	a_clear_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_new_r && ccode == 8'h08 && cparam != 8'h00
		|=> clr_slot_cnt && clr_slot_num == $past(cparam))
		else $error("slot clear wrong");
	a_cold_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_new_r && cmd_r == 16'h00F8 |=> cold_start ##1 !cold_start)
		else $error("cold start not one pulse");
	a_passive_go: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_new_r && cmd_r == 16'h00F5 && !unit_active |=> !unit_active && !partner_take)
		else $error("passive unit reacted to F5");
	a_active_go: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_new_r && cmd_r == 16'h00F6 && !unit_active && partner_present |=> unit_active)
		else $error("F6 did not activate");
	a_swap_role: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_new_r && cmd_r == 16'h00F7 && partner_present |=> unit_active != $past(unit_active))
		else $error("F7 did not swap");
	a_cu_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_r == fbioc_pkg::FBIOC_ST_IDLE && cfg_start |=> st_r == fbioc_pkg::FBIOC_ST_CU)
		else $error("string did not open with com unit");
endmodule : fbioc_core

// ==== tb/fbioc_master.sv ====
`timescale 1ns/1ps
module fbioc_master (
	input  wire logic       sys_clk,
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_byte,
	output logic            req_valid,
	output logic      [7:0] req_byte,
	output logic            req_first,
	output logic            rsp_ready
);
	logic [7:0] rx_q[$];
	initial begin
		req_valid = 1'b0;
		req_byte  = 8'hA5;
		req_first = 1'b0;
		rsp_ready = 1'b0;
	end
	task automatic send(input logic [7:0] prm, input logic [7:0] cmd);
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_first = 1'b1;
		req_byte  = prm;
		@(negedge sys_clk);
		req_first = 1'b0;
		req_byte  = cmd;
		@(negedge sys_clk);
		req_valid = 1'b0;
		// Idle line must not look like a held byte
		req_byte  = ~cmd;
	endtask : send
	task automatic get_rsp(input int n);
		int t;
		rx_q.delete();
		t = 0;
		while (rx_q.size() < n && t < 200) begin
			@(negedge sys_clk);
			// Stall every other cycle to load the buffer
			rsp_ready = t[0];
			// Judge the handshake while it stands, ahead of the edge that takes it
			#2;
			if (rsp_valid === 1'b1 && rsp_ready)
				rx_q.push_back(rsp_byte);
			t++;
		end
		@(negedge sys_clk);
		rsp_ready = 1'b0;
	endtask : get_rsp
endmodule : fbioc_master

// ==== tb/tb_fieldbus_io_config_and_command.sv ====
`timescale 1ns/1ps
module tb_fieldbus_io_config_and_command;
	logic          sys_clk;
	logic          rst_n;
	logic [1:0]    cu_mode;
	logic [143:0]  slot_words;
	logic [47:0]   slot_present;
	logic          cfg_start;
	logic          cfg_ready;
	logic          rsp_start;
	logic [15:0]   global_status;
	logic [47:0]   mod_active;
	logic [47:0]   mod_fault;
	logic          partner_present;
	wire           cfg_valid;
	wire  [7:0]    cfg_byte;
	wire           cfg_last;
	wire           req_valid;
	wire  [7:0]    req_byte;
	wire           req_first;
	wire           rsp_valid;
	wire           rsp_ready;
	wire  [7:0]    rsp_byte;
	wire           clr_all_cnt;
	wire           clr_slot_cnt;
	wire  [7:0]    clr_slot_num;
	wire           cold_start;
	wire           warm_restart;
	wire           unit_active;
	wire           partner_take;
	wire  [15:0]   last_cmd_word;
	wire  [4:0]    pulses = {clr_all_cnt, clr_slot_cnt, cold_start, warm_restart, partner_take};
	int            num_errors = 0;
	int            compares = 0;

	fbioc_core fbioc_core_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .cu_mode(cu_mode), .slot_words(slot_words),
		.slot_present(slot_present), .cfg_start(cfg_start), .cfg_valid(cfg_valid),
		.cfg_ready(cfg_ready), .cfg_byte(cfg_byte), .cfg_last(cfg_last),
		.req_valid(req_valid), .req_byte(req_byte), .req_first(req_first),
		.rsp_start(rsp_start), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
		.rsp_byte(rsp_byte), .global_status(global_status), .mod_active(mod_active),
		.mod_fault(mod_fault), .partner_present(partner_present),
		.clr_all_cnt(clr_all_cnt), .clr_slot_cnt(clr_slot_cnt),
		.clr_slot_num(clr_slot_num), .cold_start(cold_start),
		.warm_restart(warm_restart), .unit_active(unit_active), .partner_take(partner_take),
		.last_cmd_word(last_cmd_word)
	);
	fbioc_master fbioc_master_inst (
		.sys_clk(sys_clk), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
		.req_valid(req_valid), .req_byte(req_byte), .req_first(req_first),
		.rsp_ready(rsp_ready)
	);

	always #2.5 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_sim;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic do_reset;
		@(negedge sys_clk);
		rst_n = 1'b0;
		repeat (6) @(negedge sys_clk);
		rst_n = 1'b1;
		chk("unit_active", unit_active, 1'b1);
		chk("last_cmd", last_cmd_word, 16'h0000);
		chk("pulses", pulses, 5'h00);
		chk("valids", {cfg_valid, rsp_valid}, 2'h0);
		$display("test reset done");
	endtask : do_reset
	task automatic cmd(input logic [7:0] p, input logic [7:0] c, input logic [4:0] exp);
		logic [4:0] seen;
		int n;
		seen = 5'h00;
		n = 0;
		fbioc_master_inst.send(p, c);
		repeat (6) begin
			@(negedge sys_clk);
			seen = seen | pulses;
			n += (pulses != 5'h00);
		end
		chk("pulses", seen, exp);
		chk("pulse_cycles", 48'(n), exp != 5'h00);
		chk("last_cmd", last_cmd_word, {p, c});
	endtask : cmd
	task automatic t_cmds;
		partner_present = 1'b0;
		cmd(8'h00, 8'h08, 5'h10);
		cmd(8'h00, 8'h08, 5'h00);
		cmd(8'h05, 8'h08, 5'h08);
		chk("slot_num", clr_slot_num, 8'h05);
		cmd(8'h00, 8'hF8, 5'h04);
		cmd(8'h00, 8'hF9, 5'h02);
		cmd(8'h03, 8'hF9, 5'h00);
		cmd(8'h00, 8'hF7, 5'h00);
		chk("unit_active", unit_active, 1'b1);
		// No command register in the layout: the word must be left alone
		cu_mode = 2'h2;
		fbioc_master_inst.send(8'h00, 8'hF8);
		repeat (6) @(negedge sys_clk);
		chk("refused", last_cmd_word, 16'h00F7);
		cu_mode = 2'h3;
		$display("test cmds done");
	endtask : t_cmds
	task automatic t_redund;
		logic [7:0] cs[9] = '{8'hF6, 8'hF5, 8'hF7, 8'hF5, 8'hF5, 8'h08, 8'hF5, 8'hF6, 8'hF7};
		logic       ua[9] = '{1, 0, 1, 0, 0, 0, 0, 1, 0};
		logic       prev;
		logic [4:0] ex;
		partner_present = 1'b1;
		prev = 1'b1;
		for (int i = 0; i < 9; i++) begin
			// A role change must also hand the partner its pulse
			ex = (cs[i] == 8'h08) ? 5'h10 : {4'h0, ua[i] != prev};
			cmd(8'h00, cs[i], ex);
			chk("unit_active", unit_active, ua[i]);
			prev = ua[i];
		end
		$display("test redundancy done");
	endtask : t_redund
	task automatic t_rsp;
		logic [47:0] h;
		logic [7:0]  e[$];
		global_status = 16'hA53C;
		mod_active    = 48'hF0F0_1234_5678;
		mod_fault     = 48'h00FF_0000_0008;
		h = mod_active & ~mod_fault;
		for (int m = 0; m < 4; m++) begin
			cu_mode = m[1:0];
			e.delete();
			if (m[0])
				e = '{global_status[15:8], global_status[7:0]};
			for (int k = 0; k < 6 && m[1]; k++)
				e.push_back(h[47 - 8 * k -: 8]);
			@(negedge sys_clk);
			rsp_start = 1'b1;
			@(negedge sys_clk);
			rsp_start = 1'b0;
			fbioc_master_inst.get_rsp(e.size());
			chk("rsp_len", fbioc_master_inst.rx_q.size(), e.size());
			for (int k = 0; k < e.size(); k++)
				chk("rsp_byte", fbioc_master_inst.rx_q[k], e[k]);
			repeat (4) @(negedge sys_clk);
			chk("rsp_over", rsp_valid, 1'b0);
		end
		$display("test response done");
	endtask : t_rsp
	task automatic t_cfg;
		logic [7:0] sc[8] = '{8'h50, 8'h51, 8'h52, 8'h54, 8'h56, 8'h58, 8'h00, 8'h50};
		logic [7:0] e[$];
		logic [7:0] g[$];
		logic       lst;
		slot_words = '0;
		for (int s = 0; s < 6; s++)
			slot_words[3 * s +: 3] = 3'(s + 1);
		slot_words[21 +: 3] = 3'h1;
		slot_present = 48'h0000_0000_00BF;
		for (int m = 0; m < 4; m++) begin
			cu_mode = m[1:0];
			case (m)
				0: e = '{8'h00};
				1: e = '{8'h31};
				2: e = '{8'h15};
				default: e = '{8'hC0, 8'h01, 8'h07};
			endcase
			for (int s = 0; s < 8; s++)
				e.push_back(sc[s]);
			g.delete();
			lst = 1'b0;
			@(negedge sys_clk);
			cfg_start = 1'b1;
			@(negedge sys_clk);
			cfg_start = 1'b0;
			for (int t = 0; t < 200 && !lst; t++) begin
				@(negedge sys_clk);
				// Long stalls fill the buffer until it refuses
				cfg_ready = (t % 8) > 4;
				#2;
				if (cfg_valid === 1'b1 && cfg_ready) begin
					g.push_back(cfg_byte);
					lst = (cfg_last === 1'b1);
				end
			end
			@(negedge sys_clk);
			cfg_ready = 1'b0;
			chk("cfg_len", g.size(), e.size());
			for (int i = 0; i < e.size(); i++)
				chk("cfg_byte", g[i], e[i]);
		end
		$display("test config done");
	endtask : t_cfg

	initial begin
		sys_clk         = 1'b0;
		rst_n           = 1'b0;
		cu_mode         = 2'h3;
		slot_words      = '0;
		slot_present    = '0;
		cfg_start       = 1'b0;
		cfg_ready       = 1'b0;
		rsp_start       = 1'b0;
		global_status   = 16'h0000;
		mod_active      = '0;
		mod_fault       = '0;
		partner_present = 1'b0;
		do_reset();
		t_cmds();
		t_redund();
		do_reset();
		t_rsp();
		t_cfg();
		end_sim();
	end
	initial begin
		#100000;
		num_errors++;
		end_sim();
	end
endmodule : tb_fieldbus_io_config_and_command
